//--- design/ssp_setpoint.sv
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
// Contract
// - direct mode: output sum of fixed values 1..4 whose select bit is set
// - binary mode: four select bits index one of 16 stored values
// - mode field: 1 direct, 2 binary; resets to 1
// - all stored fixed values reset to zero speed
// - all four select sources reset to constant zero
// - read-only output shows effective fixed setpoint
// - status flag high while any fixed setpoint is selected; raised only by a set select bit, so low for value 0 in binary mode
// - main setpoint can be connected to the effective fixed setpoint
// - inversion signal high negates setpoint, low passes it
// - negative direction inhibited after reset; source zero enables it
// - positive inhibit at one blocks positive rotation
// - negative inhibit drivable by a binary input, high inhibits
// - four skip bands; speed never rests inside one (the minimum-speed lift is applied after the skip and can land inside a band)
// - band around zero acts as minimum running speed when on
// - speeds below minimum magnitude never a steady operating point
// - minimum speed resets to zero; dynamic source selectable
module ssp_setpoint #(
    parameter int SW = 16
) (
    input  wire logic                      CLK,
    input  wire logic                      RSTN,
    input  wire logic [ssp_pkg::AW-1:0]    AVS_ADDRESS,
    input  wire logic                      AVS_READ,
    input  wire logic                      AVS_WRITE,
    input  wire logic [ssp_pkg::DW-1:0]    AVS_WRITEDATA,
    input  wire logic [3:0]                AVS_BYTEENABLE,
    output logic      [ssp_pkg::DW-1:0]    AVS_READDATA,
    output logic                           AVS_WAITREQUEST,
    input  wire logic [ssp_pkg::NDI-1:0]   DIG_IN,
    input  wire logic [ssp_pkg::CWW-1:0]   CTRL_WORD,
    input  wire logic                      MOTOR_ON,
    input  wire logic signed [SW-1:0]      MIN_SPEED_DYN,
    output logic signed [SW-1:0]           FIXED_SPEED_EFF,
    output logic                           FIXED_ACTIVE,
    output logic signed [SW-1:0]           SETPOINT_OUT
);
    import ssp_pkg::*;

    localparam int XW = SW + 3;

    ////////////////////////////////////////////////////////////////////
    function automatic logic signed [XW-1:0] ext(
        input logic signed [SW-1:0] v);
        return XW'(v);
    endfunction

    // clip a wide result back into the speed range
    function automatic logic signed [SW-1:0] sat(
        input logic signed [XW-1:0] v);
        logic top;
        top = &v[XW-1:SW-1] | ~|v[XW-1:SW-1];
        if (top)
            return v[SW-1:0];
        return v[XW-1] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
    endfunction

    function automatic logic src_pick(input logic [1:0] s, input logic d,
                                      input logic c);
        case (s)
            SRC_ZERO: return 1'b0;
            SRC_ONE:  return 1'b1;
            SRC_DI:   return d;
            default:  return c;
        endcase
    endfunction

    function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] o,
                                               input logic [DW-1:0] n,
                                               input logic [3:0]    be);
        logic [DW-1:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = n[i*8 +: 8];
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    logic [DW-1:0]         ctrl_r;
    logic signed [SW-1:0]  min_r;
    logic signed [SW-1:0]  fix_r [NFIX];
    logic signed [SW-1:0]  lo_r  [NBAND];
    logic signed [SW-1:0]  hi_r  [NBAND];
    logic [NDI-1:0]        di_m_r;
    logic [NDI-1:0]        di_r;
    logic                  ack_r;
    logic [DW-1:0]         rdata_r;
    logic signed [SW-1:0]  eff_r;
    logic                  act_r;
    logic signed [SW-1:0]  out_r;
    logic                  hold_r;
    logic [1:0]            band_r;
    logic signed [SW-1:0]  held_r;

    // pins pass two flops; only the second one is read
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            di_m_r <= '0;
            di_r   <= '0;
        end else begin
            di_m_r <= DIG_IN;
            di_r   <= di_m_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, then the answer
    wire bus_req  = AVS_READ | AVS_WRITE;
    wire wr_fire  = AVS_WRITE & ack_r;
    wire a_ctrl   = AVS_ADDRESS == OFF_CTRL;
    wire a_min    = AVS_ADDRESS == OFF_MIN;
    wire a_stat   = AVS_ADDRESS == OFF_STAT;
    wire a_eff    = AVS_ADDRESS == OFF_EFF;
    wire a_out    = AVS_ADDRESS == OFF_OUT;
    wire a_fix    = AVS_ADDRESS[6];
    wire a_skip   = AVS_ADDRESS[6:5] == PAGE_SKIP;
    wire [3:0] fix_i  = AVS_ADDRESS[5:2];
    wire [1:0] band_i = AVS_ADDRESS[4:3];
    wire       hi_sel = AVS_ADDRESS[2];
    wire [DW-1:0] skip_rd = hi_sel ? DW'(hi_r[band_i]) : DW'(lo_r[band_i]);
    wire [DW-1:0] rd_val =
        a_ctrl ? ctrl_r :
        a_min  ? DW'(min_r) :
        a_stat ? {30'h0000_0000, hold_r, act_r} :
        a_eff  ? DW'(eff_r) :
        a_out  ? DW'(out_r) :
        a_fix  ? DW'(fix_r[fix_i]) :
        a_skip ? skip_rd : 32'h0000_0000;

    assign AVS_WAITREQUEST = bus_req & ~ack_r;
    assign AVS_READDATA    = rdata_r;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ack_r   <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= bus_req & ~ack_r;
            if (AVS_READ & ~ack_r)
                rdata_r <= rd_val;
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_r <= CTRL_RST;
            min_r  <= '0;
            for (int i = 0; i < NFIX; i++)
                fix_r[i] <= '0;
            for (int b = 0; b < NBAND; b++) begin
                lo_r[b] <= '0;
                hi_r[b] <= '0;
            end
        end else if (wr_fire) begin
            if (a_ctrl)
                ctrl_r <= be_merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE);
            if (a_min)
                min_r <= SW'(be_merge(DW'(min_r), AVS_WRITEDATA,
                                      AVS_BYTEENABLE));
            if (a_fix)
                fix_r[fix_i] <= SW'(be_merge(DW'(fix_r[fix_i]),
                                             AVS_WRITEDATA, AVS_BYTEENABLE));
            if (a_skip && hi_sel)
                hi_r[band_i] <= SW'(be_merge(DW'(hi_r[band_i]),
                                             AVS_WRITEDATA, AVS_BYTEENABLE));
            if (a_skip && !hi_sel)
                lo_r[band_i] <= SW'(be_merge(DW'(lo_r[band_i]),
                                             AVS_WRITEDATA, AVS_BYTEENABLE));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // signal sources
    logic [NSEL-1:0] sel;
    always_comb begin
        for (int k = 0; k < NSEL; k++)
            sel[k] = src_pick(ctrl_r[CTL_SEL_LSB+2*k +: 2], di_r[k],
                              CTRL_WORD[SEL_CW_LSB+k]);
    end
    wire inv_sig = src_pick(ctrl_r[CTL_INV_LSB +: 2], di_r[INV_DI_IDX],
                            CTRL_WORD[INV_CW_IDX]);
    wire neg_inh = src_pick(ctrl_r[CTL_NEG_LSB +: 2], di_r[NEG_DI_IDX],
                            CTRL_WORD[NEG_CW_IDX]);
    wire pos_inh = src_pick(ctrl_r[CTL_POS_LSB +: 2], di_r[POS_DI_IDX],
                            CTRL_WORD[POS_CW_IDX]);
    wire is_bin  = ctrl_r[CTL_MODE_LSB +: 2] == MODE_BINARY;

    ////////////////////////////////////////////////////////////////////
    // fixed setpoint selection
    logic signed [XW-1:0] dsum;
    always_comb begin
        dsum = '0;
        for (int k = 0; k < NSEL; k++)
            if (sel[k])
                dsum = dsum + ext(fix_r[k+1]);
    end
    wire signed [SW-1:0] dir_val = sat(dsum);
    wire signed [SW-1:0] bin_val = fix_r[sel];
    wire signed [SW-1:0] eff     = is_bin ? bin_val : dir_val;
    wire                 active  = |sel;

    ////////////////////////////////////////////////////////////////////
    // setpoint processing: source, invert, inhibit, skip, minimum
    wire signed [SW-1:0] main_v = ctrl_r[CTL_MAIN_BIT] ? eff : '0;
    wire signed [SW-1:0] inv_v  = inv_sig ? sat(-ext(main_v))
                                          : main_v;
    wire                 dem_neg = inv_v < 0;
    wire                 dem_pos = inv_v > 0;
    wire                 blocked = (dem_neg & neg_inh) | (dem_pos & pos_inh);
    // zero, not a mirrored speed, keeps a pump from running backwards
    wire signed [SW-1:0] dir_v  = blocked ? '0 : inv_v;

    logic       hit;
    logic [1:0] hit_b;
    always_comb begin
        hit   = 1'b0;
        hit_b = 2'h0;
        for (int b = NBAND - 1; b >= 0; b--)
            if (dir_v >= lo_r[b] && dir_v <= hi_r[b]) begin
                hit   = 1'b1;
                hit_b = 2'(b);
            end
    end
    wire signed [XW-1:0] d_lo = ext(dir_v) - ext(lo_r[hit_b]);
    wire signed [XW-1:0] d_hi = ext(hi_r[hit_b]) - ext(dir_v);
    wire signed [SW-1:0] lo_e   = lo_r[hit_b];
    wire signed [SW-1:0] hi_e   = hi_r[hit_b];
    wire                 lo_ok  = !(lo_e < 0 && neg_inh) &&
                                  !(lo_e > 0 && pos_inh);
    wire                 hi_ok  = !(hi_e < 0 && neg_inh) &&
                                  !(hi_e > 0 && pos_inh);
    // skip a forbidden edge, so a band round zero still lifts the motor
    wire                 pick_lo = lo_ok && (d_lo <= d_hi || !hi_ok);
    wire signed [SW-1:0] edge_v = pick_lo ? lo_e : hi_e;
    wire                 same_b = hold_r && band_r == hit_b;
    // a held edge stops chatter between both edges near the band middle
    wire signed [SW-1:0] skip_v = !hit ? dir_v :
                                  same_b ? held_r : edge_v;

    wire signed [SW-1:0] min_v  = ctrl_r[CTL_MINSRC_BIT] ? MIN_SPEED_DYN
                                                         : min_r;
    wire signed [XW-1:0] mag    = skip_v < 0 ? -ext(skip_v) : ext(skip_v);
    wire                 low    = mag < ext(min_v);
    wire                 go_neg = skip_v < 0 || (skip_v == 0 && pos_inh);
    wire signed [SW-1:0] lift_v = (neg_inh & pos_inh) ? '0 :
                                  go_neg ? sat(-ext(min_v)) : min_v;
    wire signed [SW-1:0] run_v  = low ? lift_v : skip_v;
    wire                 bad    = (run_v < 0 && neg_inh) ||
                                  (run_v > 0 && pos_inh);
    wire signed [SW-1:0] fin_v  = (!MOTOR_ON || bad) ? '0 : run_v;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            eff_r  <= '0;
            act_r  <= 1'b0;
            out_r  <= '0;
            hold_r <= 1'b0;
            band_r <= 2'h0;
            held_r <= '0;
        end else begin
            eff_r  <= eff;
            act_r  <= active;
            out_r  <= fin_v;
            hold_r <= hit;
            band_r <= hit_b;
            held_r <= skip_v;
        end
    end

    assign FIXED_SPEED_EFF = eff_r;
    assign FIXED_ACTIVE    = act_r;
    assign SETPOINT_OUT    = out_r;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    chk_direct_sum: assert property (
        !is_bin |=> eff_r == $past(dir_val))
        else $error("direct sum wrong");
    chk_binary_pick: assert property (
        is_bin |=> eff_r == $past(bin_val))
        else $error("binary pick wrong");
    chk_active_flag: assert property (##1 act_r == $past(|sel))
        else $error("active flag wrong");
    chk_invert_sign: assert property (
        inv_sig && main_v > 0 |-> inv_v < 0)
        else $error("inversion missing");
    chk_neg_block: assert property (neg_inh |=> !out_r[SW-1])
        else $error("negative speed while inhibited");
    chk_pos_block: assert property (pos_inh |=> out_r <= 0)
        else $error("positive speed while inhibited");
    chk_inhibit_zero: assert property (
        MOTOR_ON && blocked && skip_v == 0 && min_v <= 0 |=> out_r == 0)
        else $error("blocked demand not zero");
    chk_min_floor: assert property (
        MOTOR_ON && !neg_inh && !pos_inh && min_v >= 0 && min_v < 16'h7FFF
        |=> out_r >= $past(min_v) || -out_r >= $past(min_v))
        else $error("below minimum speed");
    chk_skip_hold: assert property (
        hit ##1 hit && same_b |-> skip_v == $past(skip_v))
        else $error("band edge not held");
    chk_motor_off: assert property (!MOTOR_ON |=> out_r == 0)
        else $error("speed while off");
    chk_bus_answer: assert property (
        bus_req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("bus answer late");

    cov_binary_run: cover property (is_bin && active ##1 MOTOR_ON);
    cov_band_hold: cover property (hit ##1 same_b [*3]);
    cov_min_lift: cover property (MOTOR_ON && low && min_v > 0);
    cov_invert: cover property (inv_sig && main_v != 0);
endmodule

//--- design/ssp_pkg.sv
package ssp_pkg;
    localparam int AW    = 7;
    localparam int DW    = 32;
    localparam int NFIX  = 16;
    localparam int NSEL  = 4;
    localparam int NBAND = 4;
    localparam int NDI   = 4;
    localparam int CWW   = 16;

    // byte offsets of the register map
    localparam logic [AW-1:0] OFF_CTRL = 7'h00;
    localparam logic [AW-1:0] OFF_MIN  = 7'h04;
    localparam logic [AW-1:0] OFF_STAT = 7'h08;
    localparam logic [AW-1:0] OFF_EFF  = 7'h0C;
    localparam logic [AW-1:0] OFF_OUT  = 7'h10;
    localparam logic [1:0]    PAGE_SKIP = 2'h1;

    // control register fields
    localparam int CTL_MODE_LSB   = 0;
    localparam int CTL_SEL_LSB    = 4;
    localparam int CTL_INV_LSB    = 12;
    localparam int CTL_NEG_LSB    = 14;
    localparam int CTL_POS_LSB    = 16;
    localparam int CTL_MAIN_BIT   = 20;
    localparam int CTL_MINSRC_BIT = 21;
    localparam logic [DW-1:0] CTRL_RST = 32'h0000_4001;

    localparam logic [1:0] MODE_BINARY = 2'h2;

    // two-bit signal source codes
    localparam logic [1:0] SRC_ZERO = 2'h0;
    localparam logic [1:0] SRC_ONE  = 2'h1;
    localparam logic [1:0] SRC_DI   = 2'h2;
    localparam logic [1:0] SRC_CW   = 2'h3;

    // which input or control word bit each source code 2/3 reaches
    localparam int SEL_CW_LSB = 4;
    localparam int INV_DI_IDX = 1;
    localparam int INV_CW_IDX = 11;
    localparam int NEG_DI_IDX = 3;
    localparam int NEG_CW_IDX = 12;
    localparam int POS_DI_IDX = 2;
    localparam int POS_CW_IDX = 13;
endpackage

//--- sim/ssp_src_model.sv
`timescale 1ns/100ps
// digital input pins and control word source, updated right after an edge
module ssp_src_model (
    input  wire logic        CLK,
    input  wire logic [3:0]  di_req,
    input  wire logic [15:0] cw_req,
    output logic      [3:0]  dig_in,
    output logic      [15:0] ctrl_word
);
    // pins move only after an edge, so the design never sees a half change
    always @(posedge CLK) begin
        dig_in    <= di_req;
        ctrl_word <= cw_req;
    end
endmodule

//--- sim/tb.sv
`timescale 1ns/100ps
module tb;
    import ssp_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, motor_on = 1'b0;
    logic [AW-1:0] addr = 7'h00;
    logic [DW-1:0] wdata = 32'h0000_0000;
    logic [DW-1:0] rdata, rv;
    logic waitreq, fix_act;
    logic [3:0] di_req = 4'h0;
    logic [15:0] cw_req = 16'h0000;
    logic [3:0] dig_in;
    logic [15:0] ctrl_word;
    logic signed [15:0] min_dyn = 16'sh0000;
    logic signed [15:0] fix_eff, sp_out;
    logic [15:0] dv [4] = '{16'h012C, 16'h07D0, 16'h0005, 16'h0007};
    logic [15:0] dmd [3] = '{16'h04B0, 16'h0708, 16'h05DC};
    logic [15:0] edg [3] = '{16'h03E8, 16'h07D0, 16'h03E8};
    logic [31:0] exp;
    int n_errors = 0, cmp_count = 0;
    always #50 clk = ~clk;
    ssp_setpoint ssp_setpoint_i (
        .CLK(clk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .DIG_IN(dig_in), .CTRL_WORD(ctrl_word), .MOTOR_ON(motor_on),
        .MIN_SPEED_DYN(min_dyn), .FIXED_SPEED_EFF(fix_eff),
        .FIXED_ACTIVE(fix_act), .SETPOINT_OUT(sp_out));
    ssp_src_model ssp_src_model_i (
        .CLK(clk), .di_req(di_req), .cw_req(cw_req),
        .dig_in(dig_in), .ctrl_word(ctrl_word));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    // request held until the edge that sees waitrequest low
    // a hang here is ended by the watchdog only
    task automatic bus(input logic w, input logic [AW-1:0] a,
                       input logic [DW-1:0] d, output logic [DW-1:0] q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        rd    <= ~w;
        wr    <= w;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic bwr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        bus(1'b1, a, d, rv);
    endtask
    task automatic brd(input logic [AW-1:0] a, input logic [DW-1:0] e);
        bus(1'b0, a, 32'h0000_0000, rv);
        chk(rv, e);
    endtask
    // covers two sync flops plus the output register
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask
    task automatic sel(input logic [3:0] c, input logic [3:0] di);
        @(posedge clk);
        cw_req <= {8'h00, c, 4'h0};
        di_req <= di;
        settle();
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        motor_on <= 1'b1;
        brd(OFF_CTRL, CTRL_RST);
        brd(OFF_MIN, 32'h0000_0000);
        for (int i = 0; i < 16; i++) brd(7'h40 + 7'(4 * i), 32'h0);
        brd(7'h18, 32'h0000_0000);
        chk(fix_act, 1'b0);
        // direct mode, all four selects from control word
        for (int i = 0; i < 4; i++) bwr(7'h44 + 7'(4 * i), dv[i]);
        bwr(OFF_CTRL, 32'h0010_0FF1);
        for (int c = 0; c < 16; c++) begin
            sel(4'(c), 4'h0);
            exp = 32'h0;
            for (int k = 0; k < 4; k++) if (c[k]) exp += dv[k];
            chk(fix_eff, exp);
            chk(fix_act, c != 0);
            chk(sp_out, exp);
        end
        // binary mode over sixteen stored values
        for (int i = 0; i < 16; i++) bwr(7'h40 + 7'(4 * i), 32'h64 + i);
        bwr(OFF_CTRL, 32'h0010_0FF2);
        for (int c = 0; c < 16; c++) begin
            sel(4'(c), 4'h0);
            chk(fix_eff, 32'h64 + c);
            chk(fix_act, c != 0);
            brd(OFF_EFF, 32'h64 + c);
        end
        // invert and negative inhibit from the pins
        bwr(OFF_CTRL, 32'h0010_AFF2);
        sel(4'h5, 4'h0);
        chk(sp_out, 32'h69);
        sel(4'h5, 4'h2);
        chk(sp_out, -32'sh69);
        sel(4'h5, 4'hA);
        chk(sp_out, 32'h0);
        bwr(OFF_CTRL, 32'h0011_0FF2);
        sel(4'h5, 4'h0);
        chk(sp_out, 32'h0);
        // invert from control word bit 11
        bwr(OFF_CTRL, 32'h0010_3FF2);
        @(posedge clk);
        cw_req <= 16'h0850;
        settle();
        chk(sp_out, -32'sh69);
        // skip band 1000..2000, entered fresh from below each time
        bwr(OFF_CTRL, 32'h0010_0FF2);
        bwr(7'h20, 32'h03E8);
        bwr(7'h24, 32'h07D0);
        sel(4'h1, 4'h0);
        for (int i = 0; i < 3; i++) begin
            bwr(7'h44, 32'h01F4);
            settle();
            bwr(7'h44, dmd[i]);
            settle();
            chk(sp_out, edg[i]);
            brd(OFF_STAT, 32'h3);
        end
        // minimum speed, static then dynamic
        bwr(7'h44, 32'h14);
        bwr(OFF_MIN, 32'h32);
        settle();
        chk(sp_out, 32'h32);
        bwr(7'h44, 32'h0);
        settle();
        chk(sp_out, 32'h32);
        min_dyn <= 16'sh0046;
        bwr(OFF_CTRL, 32'h0030_0FF2);
        settle();
        chk(sp_out, 32'h46);
        // band round zero with negative inhibited lifts to its upper edge
        bwr(OFF_CTRL, 32'h0030_4FF2);
        bwr(7'h24, 32'h0064);
        bwr(7'h20, 32'hFFFF_FF9C);
        settle();
        chk(sp_out, 32'h64);
        motor_on <= 1'b0;
        settle();
        chk(sp_out, 32'h0);
        end_sim();
    end
endmodule
